// ==== verilog/scd_divider.sv ====
// divide-by-two, four and eight clock generator with clear and freeze
`timescale 1ns/100ps
`include "scd_defs.svh"

module scd_divider (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic divider_clear,
  input wire logic freeze,
  output logic half_rate_out,
  output logic quarter_rate_out,
  output logic eighth_rate_out
);
  import scd_pkg::*;

  // clear acts as an asynchronous reset of the divider path
  logic clr_rst_n;
  assign clr_rst_n = arst_n & ~divider_clear;

  // release stage 1, falling edge: sees clear gone by the low phase
  logic rel_arm_reg;
  logic rel_arm_next;
  // release stage 2, rising edge: lets the counter run
  logic rel_hold_reg;
  logic rel_hold_next;
  // freeze stage, falling edge
  logic frz_reg;
  logic frz_next;

  logic advance;
  scd_count_t count;

  // release stages drop to zero once clear is gone
  always_comb begin
    rel_arm_next = 1'b0;
    rel_hold_next = rel_arm_reg;
  end

  always_ff @(negedge clk or negedge clr_rst_n) begin
    if (!clr_rst_n) begin
      rel_arm_reg <= `SCD_HOLD_RST;
    end else begin
      rel_arm_reg <= rel_arm_next;
    end
  end

  always_ff @(posedge clk or negedge clr_rst_n) begin
    if (!clr_rst_n) begin
      rel_hold_reg <= `SCD_HOLD_RST;
    end else begin
      rel_hold_reg <= rel_hold_next;
    end
  end

  // freeze is caught on falling edges only
  always_comb begin
    frz_next = freeze;
  end

  always_ff @(negedge clk or negedge arst_n) begin
    if (!arst_n) begin
      frz_reg <= `SCD_FRZ_RST;
    end else begin
      frz_reg <= frz_next;
    end
  end

  // counter holds while released stage is set or frozen
  assign advance = ~rel_hold_reg & ~frz_reg;

  scd_counter u_counter (
    .clk(clk),
    .rst_n(clr_rst_n),
    .advance(advance),
    .count(count)
  );

  // outputs are counter flop bits
  assign half_rate_out = count[`SCD_HALF_BIT];
  assign quarter_rate_out = count[`SCD_QUARTER_BIT];
  assign eighth_rate_out = count[`SCD_EIGHTH_BIT];

  // checking

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!arst_n);

  // clear level on the last falling edge
  logic clr_neg_reg;
  logic clr_neg_next;

  always_comb begin
    clr_neg_next = divider_clear;
  end

  always_ff @(negedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clr_neg_reg <= 1'b1;
    end else begin
      clr_neg_reg <= clr_neg_next;
    end
  end

  // release in the high phase, no freeze around it
  sequence s_rel_high;
    divider_clear ##1 (!divider_clear && !clr_neg_reg && !frz_reg && !freeze);
  endsequence

  // release in the low phase, no freeze around it
  sequence s_rel_low;
    divider_clear ##1 (!divider_clear && clr_neg_reg && !frz_reg && !freeze);
  endsequence

  property p_rel_high;
    s_rel_high ##1 (!divider_clear && !frz_reg && !freeze)
      |-> (count == `SCD_COUNT_RST) ##1 (count == `SCD_COUNT_STEP);
  endproperty
  a_rel_high: assert property (p_rel_high)
    else $error("outputs did not follow second rise after release");

  property p_rel_low;
    s_rel_low ##1 (!divider_clear && !frz_reg && !freeze) [*2]
      |-> (count == `SCD_COUNT_RST) ##1 (count == `SCD_COUNT_STEP);
  endproperty
  a_rel_low: assert property (p_rel_low)
    else $error("outputs did not follow third rise after release");

  property p_rel_low_quiet;
    s_rel_low |=> (count == `SCD_COUNT_RST);
  endproperty
  a_rel_low_quiet: assert property (p_rel_low_quiet)
    else $error("outputs moved too early after low-phase release");

  // clear is asynchronous and may land mid-attempt
  property p_freeze_take;
    disable iff (!clr_rst_n)
    (freeze && !divider_clear) [*2] |=> $stable(count);
  endproperty
  a_freeze_take: assert property (p_freeze_take)
    else $error("divider advanced after freeze was taken");

  property p_frozen_hold;
    disable iff (!clr_rst_n)
    frz_reg && !divider_clear |=> count == $past(count);
  endproperty
  a_frozen_hold: assert property (p_frozen_hold)
    else $error("divider state changed while frozen");

  property p_unfreeze;
    disable iff (!clr_rst_n)
    frz_reg ##1 (!frz_reg && !rel_hold_reg && !divider_clear)
      |=> count == scd_count_t'($past(count) + `SCD_COUNT_STEP);
  endproperty
  a_unfreeze: assert property (p_unfreeze)
    else $error("divider did not resume from held count");

  property p_half_toggle;
    disable iff (!clr_rst_n)
    advance && !divider_clear |=> half_rate_out != $past(half_rate_out);
  endproperty
  a_half_toggle: assert property (p_half_toggle)
    else $error("half rate output did not toggle");

  property p_quarter_toggle;
    disable iff (!clr_rst_n)
    advance && count[`SCD_HALF_BIT] |=> quarter_rate_out != $past(quarter_rate_out);
  endproperty
  a_quarter_toggle: assert property (p_quarter_toggle)
    else $error("quarter rate output did not toggle");

  property p_eighth_toggle;
    disable iff (!clr_rst_n)
    advance && count[`SCD_HALF_BIT] && count[`SCD_QUARTER_BIT]
      |=> eighth_rate_out != $past(eighth_rate_out);
  endproperty
  a_eighth_toggle: assert property (p_eighth_toggle)
    else $error("eighth rate output did not toggle");

  property p_idle_hold;
    disable iff (!clr_rst_n)
    !advance |=> $stable(count);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("divider moved without an advancing edge");

  property p_clear_zero;
    divider_clear |-> count == `SCD_COUNT_RST;
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("divider not held at zero during clear");

  property p_quarter_align;
    $rose(quarter_rate_out) && !divider_clear |-> $fell(half_rate_out);
  endproperty
  a_quarter_align: assert property (p_quarter_align)
    else $error("quarter rate edge not aligned to half rate edge");

  property p_eighth_align;
    $rose(eighth_rate_out) && !divider_clear
      |-> $fell(quarter_rate_out) && $fell(half_rate_out);
  endproperty
  a_eighth_align: assert property (p_eighth_align)
    else $error("eighth rate edge not aligned to faster edges");

  property p_eighth_period;
    disable iff (!clr_rst_n)
    ($rose(eighth_rate_out) && advance) ##1 (advance && !divider_clear) [*7]
      |=> $rose(eighth_rate_out);
  endproperty
  a_eighth_period: assert property (p_eighth_period)
    else $error("eighth rate period is not eight input clocks");

  c_rel_high: cover property (s_rel_high ##2 (count == `SCD_COUNT_STEP));
  c_rel_low: cover property (s_rel_low ##3 (count == `SCD_COUNT_STEP));
  c_freeze: cover property (frz_reg [*3] ##1 !frz_reg ##1 advance);
  c_wrap: cover property ($fell(eighth_rate_out) && !divider_clear);

endmodule // scd_divider

// ==== verilog/scd_defs.svh ====
// constants for the synchronous clock divider with freeze
`ifndef SCD_DEFS_SVH
`define SCD_DEFS_SVH

// width of the shared divider counter
`define SCD_CNT_W 3
// counter value after reset or clear
`define SCD_COUNT_RST 3'h0
// counter increment per advancing edge
`define SCD_COUNT_STEP 3'h1
// bit positions of the divided outputs in the counter
`define SCD_HALF_BIT 0
`define SCD_QUARTER_BIT 1
`define SCD_EIGHTH_BIT 2
// level of the release stages while clear is held
`define SCD_HOLD_RST 1'b1
// level of the freeze stage after reset
`define SCD_FRZ_RST 1'b0
// rising edges from clear release to first output change
`define SCD_REL_LAT_HIGH 2
`define SCD_REL_LAT_LOW 3

`endif

// ==== verilog/scd_pkg.sv ====
// types shared by the clock divider files
`include "scd_defs.svh"

package scd_pkg;

  typedef logic [`SCD_CNT_W-1:0] scd_count_t;

endpackage

// ==== verilog/scd_counter.sv ====
// shared synchronous divider counter with hold
`timescale 1ns/100ps
`include "scd_defs.svh"

module scd_counter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic advance,
  output scd_pkg::scd_count_t count
);
  import scd_pkg::*;

  scd_count_t count_reg;
  scd_count_t count_next;

  function automatic scd_count_t count_inc(input scd_count_t value);
    count_inc = scd_count_t'(value + `SCD_COUNT_STEP);
  endfunction

  // one counter feeds all outputs so coincident edges align
  always_comb begin
    count_next = count_reg;
    if (advance) begin
      count_next = count_inc(count_reg);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= `SCD_COUNT_RST;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;

endmodule // scd_counter

// ==== verification/scd_sink.sv ====
// downstream model that counts half-rate rising edges
`timescale 1ns/100ps

module scd_sink (
  input wire logic half_rate_out,
  output int half_rises
);
  initial half_rises = 0;
  always @(posedge half_rate_out) begin
    half_rises <= half_rises + 1;
  end
endmodule // scd_sink

// ==== verification/scd_divider_bench.sv ====
// self-checking bench for the clock divider
`timescale 1ns/100ps

module scd_divider_bench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic divider_clear = 1'b1;
  logic freeze = 1'b0;
  logic half_rate_out;
  logic quarter_rate_out;
  logic eighth_rate_out;
  logic [2:0] outs;
  logic [2:0] v;
  int half_rises;
  int miscompares = 0;
  int n_checks = 0;

  assign outs = {eighth_rate_out, quarter_rate_out, half_rate_out};

  always #5 clk = ~clk;

  scd_divider u_dut (
    .clk(clk),
    .arst_n(arst_n),
    .divider_clear(divider_clear),
    .freeze(freeze),
    .half_rate_out(half_rate_out),
    .quarter_rate_out(quarter_rate_out),
    .eighth_rate_out(eighth_rate_out)
  );

  scd_sink u_sink (
    .half_rate_out(half_rate_out),
    .half_rises(half_rises)
  );

  task chk(input string name, input logic [2:0] e, input logic [2:0] s);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, s);
    end
  endtask

  task test_done;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // release just after a rise, then one full wrap
  task rel_high;
    int h0;
    h0 = half_rises;
    @(posedge clk) divider_clear <= 1'b0;
    for (int n = 1; n <= 9; n++) begin
      @(posedge clk);
      #1 chk("outs", 3'(n - 1), outs);
    end
    chk("half rises", 3'h4, 3'(half_rises - h0));
    $display("rel_high done");
  endtask

  // clear over one rise, released in the low phase on purpose
  task rel_low;
    @(posedge clk) divider_clear <= 1'b1;
    @(posedge clk);
    #1 chk("outs cleared", 3'h0, outs);
    @(negedge clk) divider_clear <= 1'b0;
    for (int n = 1; n <= 3; n++) begin
      @(posedge clk);
      #1 chk("outs", (n == 3) ? 3'h1 : 3'h0, outs);
    end
    $display("rel_low done");
  endtask

  // hold for three rises, then resume from the held count past a wrap
  task frz;
    @(posedge clk) freeze <= 1'b1;
    #1 v = outs;
    for (int n = 1; n <= 14; n++) begin
      @(posedge clk);
      if (n == 3)
        freeze <= 1'b0;
      #1 chk("outs", v + 3'((n > 3) ? n - 3 : 0), outs);
    end
    $display("frz done");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rel_high();
    rel_low();
    frz();
    test_done();
  end

  // tests need about 33 cycles
  initial begin
    #2000;
    miscompares++;
    test_done();
  end
endmodule // scd_divider_bench
